// File: design/dtc_top.sv
// Two timer/counters with control, mode and count registers on APB.
// Assumes a 100 MHz core_clk; pins arrive asynchronously from outside.
//
// How it works
// - Overflow of timer one sets control bit 7 unless timer zero is in mode 11; vectoring acknowledge clears it.
// - Overflow of timer zero sets control bit 5; vectoring acknowledge clears it.
// - Control bit 6 starts timer one when one, stops it when zero unless timer zero is in mode 11.
// - Control bit 4 starts timer zero when one, stops it when zero.
// - Control bit 3 flags interrupt pin one; processing clears it in edge mode.
// - Control bit 1 flags interrupt pin zero; processing clears it in edge mode.
// - Control bit 2 picks low level or falling edge for interrupt one.
// - Control bit 0 picks low level or falling edge for interrupt zero.
// - Mode bit 7 set lets timer one run only while pin one is high.
// - Mode bit 3 set lets timer zero run only while pin zero is high.
// - Mode bit 6 picks divided clock or count pin falls for timer one.
// - Mode bit 2 picks divided clock or count pin falls for timer zero.
// - Timer one mode 00: high byte counts, five low bits prescale.
// - Timer zero mode 00: high byte counts, five low bits prescale.
// - Mode 01 chains high and low bytes into one 16-bit counter.
// - Timer one mode 10: low byte counts, reloads from high on overflow.
// - Timer zero mode 10: low byte counts, reloads from high on overflow.
// - Timer one mode 11 halts and keeps its count.
// - Timer zero mode 11: two 8-bit timers, high uses timer one controls.
// - Mode register and count bytes reset to zero.
// - Each count reads and writes as full high and low bytes.
// - Count pin sampled once per tick; high then low sample counts.
// - In mode 00 the upper three low-byte bits carry no meaning.
`timescale 1ns/1ps
`include "dtc_defines.svh"

module dtc_top
  import dtc_pkg::*;
#(
  parameter int TICK_DIV = `DTC_TICK_DIV
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_irq_pin_zero,
  input  wire logic        ext_irq_pin_one,
  input  wire logic        count_pin_zero,
  input  wire logic        count_pin_one,
  input  wire logic        ack_ovf_zero,
  input  wire logic        ack_ovf_one,
  input  wire logic        ack_ext_zero,
  input  wire logic        ack_ext_one,
  output logic             ovf_flag_zero,
  output logic             ovf_flag_one,
  output logic             ext_irq_edge_flag_zero,
  output logic             ext_irq_edge_flag_one
);

  if (TICK_DIV < 1 || TICK_DIV > 255) begin : g_bad_div
    $error("TICK_DIV out of range");
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic reg_hit(input dtc_addr_s a, input logic [9:0] idx);
    reg_hit = a.aligned && (a.idx == idx);
  endfunction : reg_hit

  function automatic logic mapped(input dtc_addr_s a);
    mapped = reg_hit(a, `DTC_IDX_CONTROL) || reg_hit(a, `DTC_IDX_MODE)
          || reg_hit(a, `DTC_IDX_LOW_ZERO) || reg_hit(a, `DTC_IDX_LOW_ONE)
          || reg_hit(a, `DTC_IDX_HIGH_ZERO) || reg_hit(a, `DTC_IDX_HIGH_ONE);
  endfunction : mapped

  function automatic dtc_step_s step(input dtc_mode_e mode, input logic [7:0] lo,
                                     input logic [7:0] hi, input logic inc);
    logic [5:0] pre;
    logic [8:0] wide;
    step.lo  = lo;
    step.hi  = hi;
    step.ovf = 1'b0;
    pre      = 6'h00;
    wide     = 9'h000;
    if (inc) begin
      case (mode)
        DTC_MODE_PRESC: begin
          pre = {1'b0, lo[`DTC_PRESC_MSB:0]} + 6'h01;
          step.lo[`DTC_PRESC_MSB:0] = pre[`DTC_PRESC_MSB:0];
          if (pre[5]) begin
            wide     = {1'b0, hi} + 9'h001;
            step.hi  = wide[7:0];
            step.ovf = wide[8];
          end
        end
        DTC_MODE_WIDE: begin
          wide    = {1'b0, lo} + 9'h001;
          step.lo = wide[7:0];
          if (wide[8]) begin
            wide     = {1'b0, hi} + 9'h001;
            step.hi  = wide[7:0];
            step.ovf = wide[8];
          end
        end
        DTC_MODE_RELOAD: begin
          wide     = {1'b0, lo} + 9'h001;
          step.lo  = wide[8] ? hi : wide[7:0];
          step.ovf = wide[8];
        end
        DTC_MODE_SPLIT: begin
          wide     = {1'b0, lo} + 9'h001;
          step.lo  = wide[7:0];
          step.ovf = wide[8];
        end
        default: begin
          step.ovf = 1'b0;
        end
      endcase
    end
  endfunction : step

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] timer_mode_select;
  logic [7:0] count_lower_zero;
  logic [7:0] count_upper_zero;
  logic [7:0] count_lower_one;
  logic [7:0] count_upper_one;
  logic       run_bit_zero;
  logic       run_bit_one;
  logic       ext_irq_type_zero;
  logic       ext_irq_type_one;

  // ------------------------------------------------------------
  // APB slave, zero wait states
  // ------------------------------------------------------------
  dtc_addr_s  req_addr;
  logic       wr_commit;
  logic [7:0] wbyte;

  assign req_addr.idx     = paddr[11:2];
  assign req_addr.aligned = (paddr[1:0] == 2'b00);
  assign wr_commit        = psel && penable && pready && pwrite && mapped(req_addr);
  assign wbyte            = pwdata[7:0];

  logic [7:0] ctrl_rd;
  assign ctrl_rd = {ovf_flag_one, run_bit_one, ovf_flag_zero, run_bit_zero,
                    ext_irq_edge_flag_one, ext_irq_type_one,
                    ext_irq_edge_flag_zero, ext_irq_type_zero};

  logic [7:0] next_rd;
  always_comb begin
    next_rd = 8'h00;
    if (reg_hit(req_addr, `DTC_IDX_CONTROL)) begin
      next_rd = ctrl_rd;
    end else if (reg_hit(req_addr, `DTC_IDX_MODE)) begin
      next_rd = timer_mode_select;
    end else if (reg_hit(req_addr, `DTC_IDX_LOW_ZERO)) begin
      next_rd = count_lower_zero;
    end else if (reg_hit(req_addr, `DTC_IDX_LOW_ONE)) begin
      next_rd = count_lower_one;
    end else if (reg_hit(req_addr, `DTC_IDX_HIGH_ZERO)) begin
      next_rd = count_upper_zero;
    end else if (reg_hit(req_addr, `DTC_IDX_HIGH_ONE)) begin
      next_rd = count_upper_one;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped(req_addr);
      if (psel && !penable) begin
        prdata <= {24'h00_0000, next_rd};
      end
    end
  end

  // ------------------------------------------------------------
  // Pin synchronisers and filters
  // ------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] pin_f;
  assign pin_raw = {count_pin_one, count_pin_zero, ext_irq_pin_one, ext_irq_pin_zero};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      logic [2:0] sh;
      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          sh           <= {3{`DTC_PIN_IDLE}};
          pin_f[gi]    <= `DTC_PIN_IDLE;
        end else begin
          sh <= {sh[1:0], pin_raw[gi]};
          if (sh[1] == sh[2]) begin
            pin_f[gi] <= sh[2];
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Peripheral tick divider
  // ------------------------------------------------------------
  logic [7:0] tick_cnt;
  logic       tick;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt <= 8'h00;
      tick     <= 1'b0;
    end else begin
      tick <= (tick_cnt == 8'(TICK_DIV - 1));
      if (tick_cnt == 8'(TICK_DIV - 1)) begin
        tick_cnt <= 8'h00;
      end else begin
        tick_cnt <= tick_cnt + 8'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // Count pin sampling and interrupt pin edges
  // ------------------------------------------------------------
  logic [1:0] cnt_smp;
  logic [1:0] cnt_fall;
  logic [1:0] irq_prev;
  logic [1:0] irq_fall;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_smp  <= {2{`DTC_PIN_IDLE}};
      irq_prev <= {2{`DTC_PIN_IDLE}};
    end else begin
      irq_prev <= pin_f[1:0];
      if (tick) begin
        cnt_smp <= pin_f[3:2];
      end
    end
  end
  assign cnt_fall = {2{tick}} & cnt_smp & ~pin_f[3:2];
  assign irq_fall = irq_prev & ~pin_f[1:0];

  // ------------------------------------------------------------
  // Run qualification and count events
  // ------------------------------------------------------------
  dtc_mode_e mode_zero;
  dtc_mode_e mode_one;
  logic      split_zero;
  logic      run_zero_q;
  logic      run_one_q;
  logic      inc_zero;
  logic      inc_one;
  logic      inc_upper_split;

  assign mode_zero  = dtc_mode_e'({timer_mode_select[`DTC_MOD_HI_ZERO],
                                   timer_mode_select[`DTC_MOD_LO_ZERO]});
  assign mode_one   = dtc_mode_e'({timer_mode_select[`DTC_MOD_HI_ONE],
                                   timer_mode_select[`DTC_MOD_LO_ONE]});
  assign split_zero = (mode_zero == DTC_MODE_SPLIT);

  assign run_zero_q = run_bit_zero
                   && (!timer_mode_select[`DTC_MOD_GATE_ZERO] || pin_f[0]);
  assign run_one_q  = (split_zero || run_bit_one)
                   && (!timer_mode_select[`DTC_MOD_GATE_ONE] || pin_f[1]);

  assign inc_zero = run_zero_q
                 && (timer_mode_select[`DTC_MOD_SRC_ZERO] ? cnt_fall[0] : tick);
  assign inc_one  = run_one_q && (mode_one != DTC_MODE_SPLIT)
                 && (timer_mode_select[`DTC_MOD_SRC_ONE] ? cnt_fall[1] : tick);
  assign inc_upper_split = split_zero && run_bit_one && tick;

  // ------------------------------------------------------------
  // Counting steps
  // ------------------------------------------------------------
  dtc_step_s st_zero;
  dtc_step_s st_one;
  logic [8:0] upper_split;

  // Modes 00, 01, 10 and split low byte
  assign st_zero = step(mode_zero, count_lower_zero, count_upper_zero, inc_zero);
  assign st_one  = step(mode_one, count_lower_one, count_upper_one, inc_one);
  assign upper_split = {1'b0, count_upper_zero} + {8'h00, inc_upper_split};

  logic set_ovf_zero;
  logic set_ovf_one;
  assign set_ovf_zero = st_zero.ovf;
  assign set_ovf_one  = (split_zero && inc_upper_split && upper_split[8])
                     || (!split_zero && st_one.ovf);

  // ------------------------------------------------------------
  // Mode register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_mode_select <= `DTC_RST_BYTE;
    end else if (wr_commit && reg_hit(req_addr, `DTC_IDX_MODE)) begin
      timer_mode_select <= wbyte;
    end
  end

  // ------------------------------------------------------------
  // Count bytes, software write beats counting
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_lower_zero <= `DTC_RST_BYTE;
      count_upper_zero <= `DTC_RST_BYTE;
    end else begin
      if (wr_commit && reg_hit(req_addr, `DTC_IDX_LOW_ZERO)) begin
        count_lower_zero <= wbyte;
      end else begin
        count_lower_zero <= st_zero.lo;
      end
      if (wr_commit && reg_hit(req_addr, `DTC_IDX_HIGH_ZERO)) begin
        count_upper_zero <= wbyte;
      end else if (split_zero) begin
        count_upper_zero <= upper_split[7:0];
      end else begin
        count_upper_zero <= st_zero.hi;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_lower_one <= `DTC_RST_BYTE;
      count_upper_one <= `DTC_RST_BYTE;
    end else begin
      if (wr_commit && reg_hit(req_addr, `DTC_IDX_LOW_ONE)) begin
        count_lower_one <= wbyte;
      end else begin
        count_lower_one <= st_one.lo;
      end
      if (wr_commit && reg_hit(req_addr, `DTC_IDX_HIGH_ONE)) begin
        count_upper_one <= wbyte;
      end else begin
        count_upper_one <= st_one.hi;
      end
    end
  end

  // ------------------------------------------------------------
  // Control register: run and type bits
  // ------------------------------------------------------------
  logic ctl_wr;
  assign ctl_wr = wr_commit && reg_hit(req_addr, `DTC_IDX_CONTROL);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_bit_zero      <= 1'b0;
      run_bit_one       <= 1'b0;
      ext_irq_type_zero <= 1'b0;
      ext_irq_type_one  <= 1'b0;
    end else if (ctl_wr) begin
      run_bit_zero      <= wbyte[`DTC_CTL_RUN_ZERO];
      run_bit_one       <= wbyte[`DTC_CTL_RUN_ONE];
      ext_irq_type_zero <= wbyte[`DTC_CTL_TYPE_ZERO];
      ext_irq_type_one  <= wbyte[`DTC_CTL_TYPE_ONE];
    end
  end

  // ------------------------------------------------------------
  // Overflow flags, a set beats any clear
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovf_flag_zero <= 1'b0;
      ovf_flag_one  <= 1'b0;
    end else begin
      if (set_ovf_zero) begin
        ovf_flag_zero <= 1'b1;
      end else if (ack_ovf_zero) begin
        ovf_flag_zero <= 1'b0;
      end else if (ctl_wr) begin
        ovf_flag_zero <= wbyte[`DTC_CTL_OVF_ZERO];
      end
      if (set_ovf_one) begin
        ovf_flag_one <= 1'b1;
      end else if (ack_ovf_one) begin
        ovf_flag_one <= 1'b0;
      end else if (ctl_wr) begin
        ovf_flag_one <= wbyte[`DTC_CTL_OVF_ONE];
      end
    end
  end

  // ------------------------------------------------------------
  // External interrupt flags
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_irq_edge_flag_zero <= 1'b0;
      ext_irq_edge_flag_one  <= 1'b0;
    end else begin
      if (!ext_irq_type_zero) begin
        ext_irq_edge_flag_zero <= !pin_f[0];
      end else if (irq_fall[0]) begin
        ext_irq_edge_flag_zero <= 1'b1;
      end else if (ack_ext_zero) begin
        ext_irq_edge_flag_zero <= 1'b0;
      end else if (ctl_wr) begin
        ext_irq_edge_flag_zero <= wbyte[`DTC_CTL_EDGE_ZERO];
      end
      if (!ext_irq_type_one) begin
        ext_irq_edge_flag_one <= !pin_f[1];
      end else if (irq_fall[1]) begin
        ext_irq_edge_flag_one <= 1'b1;
      end else if (ack_ext_one) begin
        ext_irq_edge_flag_one <= 1'b0;
      end else if (ctl_wr) begin
        ext_irq_edge_flag_one <= wbyte[`DTC_CTL_EDGE_ONE];
      end
    end
  end

endmodule : dtc_top

// File: design/dtc_defines.svh
// Constants of the dual timer control block: register indices, bits, resets.
// Assumes inclusion by bare name from the package and the top module.
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH

// ------------------------------------------------------------
// Register indices, byte address is four times the index
// ------------------------------------------------------------
`define DTC_IDX_CONTROL    10'h088
`define DTC_IDX_MODE       10'h089
`define DTC_IDX_LOW_ZERO   10'h08a
`define DTC_IDX_LOW_ONE    10'h08b
`define DTC_IDX_HIGH_ZERO  10'h08c
`define DTC_IDX_HIGH_ONE   10'h08d

// ------------------------------------------------------------
// Control register bits
// ------------------------------------------------------------
`define DTC_CTL_OVF_ONE    7
`define DTC_CTL_RUN_ONE    6
`define DTC_CTL_OVF_ZERO   5
`define DTC_CTL_RUN_ZERO   4
`define DTC_CTL_EDGE_ONE   3
`define DTC_CTL_TYPE_ONE   2
`define DTC_CTL_EDGE_ZERO  1
`define DTC_CTL_TYPE_ZERO  0

// ------------------------------------------------------------
// Mode register bits
// ------------------------------------------------------------
`define DTC_MOD_GATE_ONE   7
`define DTC_MOD_SRC_ONE    6
`define DTC_MOD_HI_ONE     5
`define DTC_MOD_LO_ONE     4
`define DTC_MOD_GATE_ZERO  3
`define DTC_MOD_SRC_ZERO   2
`define DTC_MOD_HI_ZERO    1
`define DTC_MOD_LO_ZERO    0

// ------------------------------------------------------------
// Reset values, prescaler width and timing
// ------------------------------------------------------------
`define DTC_RST_BYTE       8'h00
`define DTC_PRESC_MSB      4
`define DTC_TICK_DIV       6
`define DTC_PIN_IDLE       1'b1

`endif

// File: design/dtc_pkg.sv
// Types shared by the dual timer control block.
// Assumes dtc_defines.svh is on the include path.
package dtc_pkg;
  `include "dtc_defines.svh"

  // ------------------------------------------------------------
  // Operating modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    DTC_MODE_PRESC,
    DTC_MODE_WIDE,
    DTC_MODE_RELOAD,
    DTC_MODE_SPLIT
  } dtc_mode_e;

  // ------------------------------------------------------------
  // Result of one counting step
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic       ovf;
  } dtc_step_s;

  // ------------------------------------------------------------
  // Decoded APB request address, taken straight from paddr
  // ------------------------------------------------------------
  typedef struct packed {
    logic [9:0] idx;
    logic       aligned;
  } dtc_addr_s;
endpackage : dtc_pkg

// File: sim/dtc_sva.sv
// Port checker of the dual timer control block.
// Assumes it is bound to dtc_top; one clock domain.
`timescale 1ns/1ps

module dtc_sva (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ext_irq_pin_zero,
  input wire logic        ext_irq_pin_one,
  input wire logic        ack_ovf_zero,
  input wire logic        ack_ovf_one,
  input wire logic        ovf_flag_zero,
  input wire logic        ovf_flag_one,
  input wire logic        ext_irq_edge_flag_zero,
  input wire logic        ext_irq_edge_flag_one
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  logic       wr_done;
  logic [2:0] age_zero;
  logic [2:0] age_one;

  assign wr_done = psel && penable && pwrite && pready;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      age_zero <= 3'h7;
    end else begin
      age_zero <= !ext_irq_pin_zero ? 3'h0 : (age_zero == 3'h7 ? 3'h7 : age_zero + 3'h1);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      age_one <= 3'h7;
    end else begin
      age_one <= !ext_irq_pin_one ? 3'h0 : (age_one == 3'h7 ? 3'h7 : age_one + 3'h1);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_answer;
    pready ##1 !pready;
  endsequence

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_setup_answer: assert property (s_setup |=> s_answer)
    else $error("pready not a single pulse after setup");
  a_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer carries data");
  a_read_width: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data above byte not zero");
  a_ovf_hold_zero: assert property (ovf_flag_zero && !ack_ovf_zero && !wr_done |=> ovf_flag_zero)
    else $error("overflow flag zero dropped unasked");
  a_ovf_hold_one: assert property (ovf_flag_one && !ack_ovf_one && !wr_done |=> ovf_flag_one)
    else $error("overflow flag one dropped unasked");
  a_ext_cause_zero: assert property ($rose(ext_irq_edge_flag_zero) && !$past(wr_done) |-> age_zero < 3'h7)
    else $error("edge flag zero set without pin low");
  a_ext_cause_one: assert property ($rose(ext_irq_edge_flag_one) && !$past(wr_done) |-> age_one < 3'h7)
    else $error("edge flag one set without pin low");
  a_reset_clear: assert property ($fell(sys_rst) |-> !ovf_flag_zero && !ovf_flag_one && !pready)
    else $error("outputs not clear after reset");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
endmodule : dtc_sva

// File: sim/dtc_far.sv
// Pin and vectoring model of the core side of the timer block.
// Assumes the bench calls its tasks just after a rising edge.
`timescale 1ns/1ps

module dtc_far (
  input  wire logic       core_clk,
  output logic      [1:0] ext_irq_pin,
  output logic      [1:0] count_pin,
  output logic      [1:0] ack_ovf,
  output logic      [1:0] ack_ext
);
  // ------------------------------------------------------------
  // Idle levels: pins pulled high, no vectoring
  // ------------------------------------------------------------
  initial begin
    ext_irq_pin = 2'b11;
    count_pin = 2'b11;
    ack_ovf = 2'b00;
    ack_ext = 2'b00;
  end

  task automatic irq_level(input int t, input logic v);
    @(posedge core_clk);
    ext_irq_pin[t] <= v;
  endtask : irq_level

  task automatic count_fall(input int t, input int hold);
    @(posedge core_clk);
    count_pin[t] <= 1'b0;
    repeat (hold) @(posedge core_clk);
    count_pin[t] <= 1'b1;
    repeat (hold) @(posedge core_clk);
  endtask : count_fall

  task automatic vector(input logic ext, input int t);
    @(posedge core_clk);
    if (ext) ack_ext[t] <= 1'b1;
    else ack_ovf[t] <= 1'b1;
    @(posedge core_clk);
    ack_ext[t] <= 1'b0;
    ack_ovf[t] <= 1'b0;
  endtask : vector
endmodule : dtc_far

// File: sim/testbench.sv
// Self-checking bench of the dual timer control block.
// Assumes design, checker and pin model compile first.
`timescale 1ns/1ps
`include "dtc_defines.svh"

`define CHK(g, e) begin \
  checked++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); \
  end \
end

module testbench;
  import dtc_pkg::*;
  logic        core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0]  ovf, edg, xpin, cpin, aovf, aext;
  logic [7:0]  lo, hi, ql, qh;
  logic [31:0] seed = 32'hc;
  int          t;
  int          n_errors = 0;
  int          checked = 0;

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  dtc_top #(.TICK_DIV(2)) DUT (
    .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .ext_irq_pin_zero(xpin[0]), .ext_irq_pin_one(xpin[1]),
    .count_pin_zero(cpin[0]), .count_pin_one(cpin[1]),
    .ack_ovf_zero(aovf[0]), .ack_ovf_one(aovf[1]),
    .ack_ext_zero(aext[0]), .ack_ext_one(aext[1]),
    .ovf_flag_zero(ovf[0]), .ovf_flag_one(ovf[1]),
    .ext_irq_edge_flag_zero(edg[0]), .ext_irq_edge_flag_one(edg[1]));

  dtc_far FAR (.core_clk(core_clk), .ext_irq_pin(xpin), .count_pin(cpin),
    .ack_ovf(aovf), .ack_ext(aext));

  // ------------------------------------------------------------
  // Expectation helpers and bus tasks
  // ------------------------------------------------------------
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  function automatic logic [11:0] ad(input logic [9:0] i);
    return {i, 2'b00};
  endfunction : ad

  function automatic logic [7:0] fld(input int k, input logic [3:0] f);
    return k ? {f, 4'h0} : {4'h0, f};
  endfunction : fld

  function automatic logic [7:0] rb(input int k);
    return k ? 8'h40 : 8'h10;
  endfunction : rb

  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : xfer

  task automatic start(input logic [7:0] ctl, input logic [7:0] md);
    xfer(1'b1, ad(`DTC_IDX_CONTROL), 8'h00);
    xfer(1'b1, ad(`DTC_IDX_MODE), md);
    xfer(1'b1, ad(`DTC_IDX_LOW_ZERO + 10'(t)), lo);
    xfer(1'b1, ad(`DTC_IDX_HIGH_ZERO + 10'(t)), hi);
    xfer(1'b1, ad(`DTC_IDX_CONTROL), ctl);
  endtask : start

  task automatic finish(input int n);
    repeat (n) @(posedge core_clk);
    xfer(1'b0, ad(`DTC_IDX_CONTROL), 8'h00);
    xfer(1'b1, ad(`DTC_IDX_CONTROL), q[7:0] & 8'haf);
    xfer(1'b0, ad(`DTC_IDX_LOW_ZERO + 10'(t)), 8'h00);
    ql = q[7:0];
    xfer(1'b0, ad(`DTC_IDX_HIGH_ZERO + 10'(t)), 8'h00);
    qh = q[7:0];
  endtask : finish

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 6; i++) begin
      xfer(1'b0, ad(`DTC_IDX_CONTROL + 10'(i)), 8'h00);
      `CHK(q, 32'h0)
    end
    xfer(1'b0, 12'h3fc, 8'h00);
    `CHK({err, q}, {1'b1, 32'h0})
    for (int i = 1; i < 6; i++) begin
      lo = rnd();
      xfer(1'b1, ad(`DTC_IDX_CONTROL + 10'(i)), lo);
      xfer(1'b0, ad(`DTC_IDX_CONTROL + 10'(i)), 8'h00);
      `CHK(q, {24'h0, lo})
    end
    xfer(1'b1, ad(`DTC_IDX_CONTROL), 8'h55);
    xfer(1'b0, ad(`DTC_IDX_CONTROL), 8'h00);
    `CHK(q[7:0] & 8'h55, 8'h55)
    for (t = 0; t < 2; t++) begin
      hi = rnd();
      lo = 8'hff;
      start(rb(t), fld(t, 4'h1));
      finish(20);
      `CHK({qh, ovf[t]}, {hi + 8'h1, hi == 8'hff})
      start(rb(t), fld(t, 4'h0));
      finish(20);
      `CHK({qh, ql[7:5]}, {hi + 8'h1, 3'h7})
      hi = rnd() | 8'h80;
      start(rb(t), fld(t, 4'h2));
      finish(20);
      `CHK({qh, ovf[t], ql >= hi}, {hi, 2'b11})
      FAR.vector(1'b0, t);
      @(posedge core_clk);
      `CHK(ovf[t], 1'b0)
      FAR.irq_level(t, 1'b0);
      start(rb(t), fld(t, 4'h9));
      finish(20);
      `CHK({qh, ql}, {hi, lo})
      FAR.irq_level(t, 1'b1);
      lo = 8'h00;
      start(rb(t), fld(t, 4'h5));
      repeat (3) FAR.count_fall(t, 6);
      finish(6);
      `CHK(ql, 8'h03)
      lo = rnd();
      hi = rnd();
      start(t ? 8'h50 : 8'h40, fld(t, 4'h3));
      finish(20);
      `CHK(t ? {qh, ql} === {hi, lo} : ql === lo && qh !== hi, 1'b1)
      xfer(1'b1, ad(`DTC_IDX_CONTROL), 8'h05);
      FAR.irq_level(t, 1'b0);
      repeat (8) @(posedge core_clk);
      FAR.irq_level(t, 1'b1);
      repeat (8) @(posedge core_clk);
      `CHK(edg[t], 1'b1)
      FAR.vector(1'b1, t);
      @(posedge core_clk);
      `CHK(edg[t], 1'b0)
      xfer(1'b1, ad(`DTC_IDX_CONTROL), 8'h00);
      FAR.irq_level(t, 1'b0);
      repeat (8) @(posedge core_clk);
      FAR.vector(1'b1, t);
      @(posedge core_clk);
      xfer(1'b0, ad(`DTC_IDX_CONTROL), 8'h00);
      `CHK(q[1 + 2 * t], 1'b1)
      FAR.irq_level(t, 1'b1);
      repeat (8) @(posedge core_clk);
      `CHK(edg[t], 1'b0)
    end
    summarize();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    summarize();
  end
endmodule : testbench

bind dtc_top dtc_sva u_sva (
  .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_irq_pin_zero(ext_irq_pin_zero), .ext_irq_pin_one(ext_irq_pin_one),
  .ack_ovf_zero(ack_ovf_zero), .ack_ovf_one(ack_ovf_one),
  .ovf_flag_zero(ovf_flag_zero), .ovf_flag_one(ovf_flag_one),
  .ext_irq_edge_flag_zero(ext_irq_edge_flag_zero),
  .ext_irq_edge_flag_one(ext_irq_edge_flag_one));
